// ---- fls_pkg.sv ----
// package of constants and types for the fuse, lock and signature access block
package fls_pkg;
    // fuse bit positions, high byte
    localparam int HI_RST_DIS = 7;
    localparam int HI_DBG_EN = 6;
    localparam int HI_SER_EN = 5;
    localparam int HI_WDT_ON = 4;
    localparam int HI_EE_KEEP = 3;
    // fuse bit positions, low byte
    localparam int LO_PRESCALE = 7;
    localparam int LO_CLK_OUT = 6;
    // reset values (0 = programmed)
    localparam logic [7:0] FUSE_HIGH_RESET = 8'hDF;
    localparam logic [7:0] FUSE_LOW_RESET = 8'h6E;
    localparam logic [7:0] FUSE_EXT_RESET = 8'hFF;
    localparam logic [7:0] LOCK_RESET = 8'hFF;
    localparam logic [7:0] LOW_UNUSED_MASK = 8'h0C;
    // Z pointer selections for fuse and lock reads
    localparam logic [15:0] Z_FUSE_LOW = 16'h0000;
    localparam logic [15:0] Z_LOCK = 16'h0001;
    localparam logic [15:0] Z_FUSE_EXT = 16'h0002;
    localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
    // table byte addresses
    localparam logic [5:0] TBL_SIG0 = 6'h00;
    localparam logic [5:0] TBL_FAST_TRIM = 6'h01;
    localparam logic [5:0] TBL_SIG1 = 6'h02;
    localparam logic [5:0] TBL_TEMP_A = 6'h03;
    localparam logic [5:0] TBL_SIG2 = 6'h04;
    localparam logic [5:0] TBL_TEMP_B = 6'h05;
    localparam logic [5:0] TBL_SLOW_TRIM = 6'h07;
    localparam logic [5:0] TBL_TS_GAIN = 6'h2C;
    localparam logic [5:0] TBL_TS_OFFSET = 6'h2D;
    // arming windows in CPU cycles
    localparam logic [2:0] LOAD_WINDOW = 3'h3;
    localparam logic [2:0] STORE_WINDOW = 3'h4;
    // controller registers
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_ZPTR = 4'h1;
    localparam logic [3:0] REG_DATA = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam int CMD_GO = 0;
    localparam int CMD_SIG = 1;
    localparam int CMD_LATE = 2;
    // read kinds
    typedef enum logic [1:0] {
        FLS_RD_NONE = 2'h0,
        FLS_RD_FUSE = 2'h1,
        FLS_RD_SIG = 2'h2
    } fls_arm_t;
endpackage

// ---- fls_link_if.sv ----
// interface between the core-side controller and the config-access device
`timescale 1ns/1ps
interface fls_link_if;
    logic armFuse;
    logic armSig;
    logic loadValid;
    logic storeValid;
    logic [15:0] zPtr;
    logic [7:0] loadData;
    logic loadDone;
    logic armActive;
    modport dev (input armFuse, armSig, loadValid, storeValid, zPtr,
        output loadData, loadDone, armActive);
    modport core (output armFuse, armSig, loadValid, storeValid, zPtr,
        input loadData, loadDone, armActive);
endinterface

// ---- fls_device.sv ----
// fuse, lock bit and signature table access logic of the device
//
// Notes on behaviour
// (RULE1) high fuse: bits 7..3 named, 2..0 brownout
// (RULE2) high fuse defaults one, serial enable zero
// (RULE3) serial route cannot touch serial enable fuse
// (RULE4) reset/debug fuse block serial, parallel clears
// (RULE5) low fuse: prescale, clkout, startup, unused, source
// (RULE6) low fuse defaults select 8 MHz oscillator
// (RULE7) lock bit one freezes all fuse writes
// (RULE8) chip erase leaves fuses alone
// (RULE9) fuses latched on programming mode entry
// (RULE10) eeprom keep fuse acts at once
// (RULE11) fuses latched at power-up in normal mode
// (RULE12) internal byte addresses, external word addresses
// (RULE13) signatures even bytes, trims odd bytes
// (RULE14) sensor gain 0x2C, offset 0x2D
// (RULE15) signature readable even when locked
// (RULE16) trims copied to calibration registers at reset
// (RULE17) programmed reads 0, unprogrammed reads 1
// (RULE18) lock read: Z 1, arm, load within three
// (RULE19) arm clears on read or window expiry
// (RULE20) unarmed load reads program memory
// (RULE21) fuse reads at Z 0, 3, 2
// (RULE22) table read: arm signature, load within three
// (RULE23) eeprom keep spares eeprom on erase
// (RULE24) late load returns program memory
`timescale 1ns/1ps
module fls_device #(
    parameter logic [7:0] SIG_BYTE0 = 8'hA5, // arbitrary identity value
    parameter logic [7:0] SIG_BYTE1 = 8'h5A, // arbitrary identity value
    parameter logic [7:0] SIG_BYTE2 = 8'h3C, // arbitrary identity value
    parameter logic [7:0] FAST_TRIM = 8'h80,
    parameter logic [7:0] SLOW_TRIM = 8'h80,
    parameter logic [7:0] TEMP_TRIM_A = 8'h00,
    parameter logic [7:0] TEMP_TRIM_B = 8'h00,
    parameter logic [7:0] TS_GAIN = 8'h80,
    parameter logic [7:0] TS_OFFSET = 8'h00
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // link to the core
    fls_link_if.dev link,
    // program memory data for ordinary loads
    input wire logic [7:0] progMemData,
    // external programming access
    input wire logic progMode,
    input wire logic progSerial,
    input wire logic fuseWrHigh,
    input wire logic fuseWrLow,
    input wire logic fuseWrExt,
    input wire logic lockWr,
    input wire logic chipErase,
    input wire logic [7:0] progWrData,
    input wire logic [5:0] progWordAddr,
    input wire logic progWordHigh,
    // external read-back
    output logic [7:0] progRdData,
    // latched fuse values, unlatched eeprom controls and oscillator trims to the chip
    output logic [7:0] fuseHighActive,
    output logic [7:0] fuseLowActive,
    output logic [7:0] fuseExtActive,
    output logic eepromKeep,
    output logic eepromErase,
    output logic [7:0] fastOscTrim,
    output logic [7:0] slowOscTrim
);
    logic [7:0] fuseHigh_q;
    logic [7:0] fuseLow_q;
    logic [7:0] fuseExt_q;
    logic [7:0] lock_q;
    logic progMode_q;
    fls_pkg::fls_arm_t arm_q;
    logic [2:0] armCnt_q;
    logic [7:0] loadData_q;
    logic loadDone_q;

    // table lookup by internal byte address
    function automatic logic [7:0] tableByte(input logic [5:0] addr);
        case (addr) // (RULE13) (RULE14)
            fls_pkg::TBL_SIG0: tableByte = SIG_BYTE0;
            fls_pkg::TBL_FAST_TRIM: tableByte = FAST_TRIM;
            fls_pkg::TBL_SIG1: tableByte = SIG_BYTE1;
            fls_pkg::TBL_TEMP_A: tableByte = TEMP_TRIM_A;
            fls_pkg::TBL_SIG2: tableByte = SIG_BYTE2;
            fls_pkg::TBL_TEMP_B: tableByte = TEMP_TRIM_B;
            fls_pkg::TBL_SLOW_TRIM: tableByte = SLOW_TRIM;
            fls_pkg::TBL_TS_GAIN: tableByte = TS_GAIN;
            fls_pkg::TBL_TS_OFFSET: tableByte = TS_OFFSET;
            default: tableByte = 8'hFF; // reserved
        endcase
    endfunction

    // serial route is shut once reset-disable or debug fuse is programmed;
    // the parallel route stays open so either fuse can still be cleared
    logic progAllowed;
    assign progAllowed = progMode && !(progSerial && !(fuseHighActive[fls_pkg::HI_RST_DIS]
        && fuseHighActive[fls_pkg::HI_DBG_EN])); // (RULE4)

    // fuse and lock storage; stored as raw 0=programmed values
    logic fuseWritable;
    assign fuseWritable = lock_q[0] && progAllowed; // (RULE7) (RULE4)
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fuseHigh_q <= fls_pkg::FUSE_HIGH_RESET; // (RULE1) (RULE2)
            fuseLow_q <= fls_pkg::FUSE_LOW_RESET; // (RULE5) (RULE6)
            fuseExt_q <= fls_pkg::FUSE_EXT_RESET;
        end else if (fuseWritable) begin
            if (fuseWrHigh) begin
                fuseHigh_q <= progWrData;
                // serial route keeps the serial enable fuse as is
                if (progSerial) begin
                    fuseHigh_q[fls_pkg::HI_SER_EN] <= fuseHigh_q[fls_pkg::HI_SER_EN]; // (RULE3)
                end
            end
            if (fuseWrLow) begin
                fuseLow_q <= progWrData | fls_pkg::LOW_UNUSED_MASK; // (RULE5)
            end
            if (fuseWrExt) begin
                fuseExt_q <= progWrData;
            end
        end
    end

    // lock bits: programmable, cleared only by erase; erase skips fuses
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lock_q <= fls_pkg::LOCK_RESET;
        end else if (progAllowed && chipErase) begin
            lock_q <= fls_pkg::LOCK_RESET; // (RULE8)
        end else if (progAllowed && lockWr) begin
            lock_q <= lock_q & progWrData; // bits can only be programmed
        end
    end

    // active copies follow storage outside programming mode and in its first cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            progMode_q <= 1'b0;
            fuseHighActive <= fls_pkg::FUSE_HIGH_RESET; // (RULE11)
            fuseLowActive <= fls_pkg::FUSE_LOW_RESET;
            fuseExtActive <= fls_pkg::FUSE_EXT_RESET;
        end else begin
            progMode_q <= progMode;
            if (!progMode || !progMode_q) begin
                fuseHighActive <= fuseHigh_q; // (RULE9) (RULE11)
                fuseLowActive <= fuseLow_q;
                fuseExtActive <= fuseExt_q;
            end
        end
    end

    // eeprom keep bypasses the latch so it acts while still programming
    assign eepromKeep = ~fuseHigh_q[fls_pkg::HI_EE_KEEP]; // (RULE10)
    assign eepromErase = progAllowed && chipErase && !eepromKeep; // (RULE23) (RULE4)

    // calibration copy during reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fastOscTrim <= FAST_TRIM; // (RULE16)
            slowOscTrim <= SLOW_TRIM;
        end
    end

    // external read-back: word address picks a pair of table bytes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            progRdData <= 8'h00;
        end else begin
            // signature read never checks lock state
            progRdData <= tableByte({progWordAddr[4:0], progWordHigh}); // (RULE12) (RULE15)
        end
    end

    // arming window; a store also clears it, and both use the load window
    always_ff @(posedge core_clk) begin
        if (rst) begin
            arm_q <= fls_pkg::FLS_RD_NONE;
            armCnt_q <= 3'h0;
        end else if (link.armFuse || link.armSig) begin
            arm_q <= link.armSig ? fls_pkg::FLS_RD_SIG : fls_pkg::FLS_RD_FUSE; // (RULE18) (RULE22)
            armCnt_q <= 3'h0;
        end else if (arm_q != fls_pkg::FLS_RD_NONE) begin
            if (link.loadValid || link.storeValid) begin
                arm_q <= fls_pkg::FLS_RD_NONE; // (RULE19)
            end else if (armCnt_q + 3'h1 >= fls_pkg::LOAD_WINDOW) begin
                arm_q <= fls_pkg::FLS_RD_NONE; // (RULE19) (RULE24)
            end else begin
                armCnt_q <= armCnt_q + 3'h1;
            end
        end
    end

    // load answer one cycle after the load
    always_ff @(posedge core_clk) begin
        if (rst) begin
            loadData_q <= 8'h00;
            loadDone_q <= 1'b0;
        end else begin
            loadDone_q <= link.loadValid;
            if (link.loadValid) begin
                case (arm_q)
                    fls_pkg::FLS_RD_FUSE: begin
                        case (link.zPtr) // (RULE21) (RULE17)
                            fls_pkg::Z_FUSE_LOW: loadData_q <= fuseLow_q;
                            fls_pkg::Z_LOCK: loadData_q <= lock_q; // (RULE18)
                            fls_pkg::Z_FUSE_EXT: loadData_q <= fuseExt_q;
                            fls_pkg::Z_FUSE_HIGH: loadData_q <= fuseHigh_q;
                            default: loadData_q <= 8'hFF;
                        endcase
                    end
                    fls_pkg::FLS_RD_SIG: loadData_q <= tableByte(link.zPtr[5:0]); // (RULE22)
                    default: loadData_q <= progMemData; // (RULE20) (RULE24)
                endcase
            end
        end
    end

    assign link.loadData = loadData_q;
    assign link.loadDone = loadDone_q;
    assign link.armActive = (arm_q != fls_pkg::FLS_RD_NONE);
endmodule // fls_device

// ---- fls_core.sv ----
// core-side controller issuing arm and load sequences to the device
`timescale 1ns/1ps
module fls_core (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // software register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdData,
    // link to the device
    fls_link_if.core link
);
    typedef enum logic [3:0] {
        IDLE = 4'b0001,
        ARM = 4'b0010,
        WAIT = 4'b0100,
        LOAD = 4'b1000
    } fls_state_t;
    fls_state_t state_q;
    logic [15:0] zPtr_q;
    logic sig_q;
    logic late_q;
    logic [1:0] waitCnt_q;
    logic [7:0] data_q;
    logic done_q;
    logic busy;

    assign busy = (state_q != IDLE);

    // Z pointer register, refused while busy so the read stays coherent
    always_ff @(posedge core_clk) begin
        if (rst) begin
            zPtr_q <= 16'h0000;
        end else if (regWr && regAddr == fls_pkg::REG_ZPTR && !busy) begin
            zPtr_q <= regWrData;
        end
    end

    // sequencer: arm, optionally wait past the window, then load
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= IDLE;
            sig_q <= 1'b0;
            late_q <= 1'b0;
            waitCnt_q <= 2'h0;
        end else begin
            case (state_q)
                IDLE: begin
                    if (regWr && regAddr == fls_pkg::REG_CMD && regWrData[fls_pkg::CMD_GO]) begin
                        sig_q <= regWrData[fls_pkg::CMD_SIG];
                        late_q <= regWrData[fls_pkg::CMD_LATE];
                        state_q <= ARM;
                    end
                end
                ARM: begin
                    waitCnt_q <= 2'h0;
                    state_q <= late_q ? WAIT : LOAD; // (RULE18) (RULE22)
                end
                WAIT: begin
                    // late test: load after the window closes
                    waitCnt_q <= waitCnt_q + 2'h1;
                    if (waitCnt_q == 2'h3) begin
                        state_q <= LOAD;
                    end
                end
                LOAD: state_q <= IDLE;
                default: state_q <= IDLE;
            endcase
        end
    end

    // result capture; done is sticky, set wins over a read clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            data_q <= 8'h00;
            done_q <= 1'b0;
        end else if (link.loadDone) begin
            data_q <= link.loadData;
            done_q <= 1'b1;
        end else if (regRd && regAddr == fls_pkg::REG_STATUS) begin
            done_q <= 1'b0;
        end
    end

    // register read, one cycle later
    always_ff @(posedge core_clk) begin
        if (rst) begin
            regRdData <= 16'h0000;
        end else if (regRd) begin
            case (regAddr)
                fls_pkg::REG_ZPTR: regRdData <= zPtr_q;
                fls_pkg::REG_DATA: regRdData <= {8'h00, data_q};
                fls_pkg::REG_STATUS: regRdData <= {13'h0000, link.armActive, busy, done_q};
                default: regRdData <= 16'h0000;
            endcase
        end
    end

    assign link.armFuse = (state_q == ARM) && !sig_q;
    assign link.armSig = (state_q == ARM) && sig_q;
    assign link.loadValid = (state_q == LOAD);
    assign link.storeValid = 1'b0; // stores are not issued by this controller
    assign link.zPtr = zPtr_q;
endmodule // fls_core

// ---- fls_props.sv ----
// assertions on the link between the core controller and the device
`timescale 1ns/1ps
module fls_props (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // link signals
    input wire logic armFuse,
    input wire logic armSig,
    input wire logic loadValid,
    input wire logic storeValid,
    input wire logic [15:0] zPtr,
    input wire logic [7:0] loadData,
    input wire logic loadDone,
    input wire logic armActive
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // an arm pulse of either kind
    sequence arm_s;
        armFuse || armSig;
    endsequence
    // three cycles with no load, store or new arm after arming
    sequence quiet_s;
        arm_s ##1 (!loadValid && !storeValid && !armFuse && !armSig) [*3];
    endsequence
    load_answer_a: assert property (loadValid |=> loadDone)
        else $error("load not answered in the next cycle");
    answer_cause_a: assert property (loadDone |-> $past(loadValid))
        else $error("load answer without a load");
    arm_live_a: assert property (arm_s |=> armActive)
        else $error("arm not live after arm pulse");
    arm_expire_a: assert property (quiet_s |=> !armActive)
        else $error("arm outlived its load window");
    clear_on_load_a: assert property (armActive && loadValid && !armFuse && !armSig
        |=> !armActive)
        else $error("arm not cleared by load");
    late_load_a: assert property (quiet_s ##[1:4] loadValid |-> !armActive)
        else $error("late load still armed");
    zptr_hold_a: assert property (armActive && $past(armActive) |-> $stable(zPtr))
        else $error("pointer moved while armed");
    one_kind_a: assert property (!(armFuse && armSig))
        else $error("both arm kinds at once");
    // main traffic: a load inside the window
    win_load_c: cover property (arm_s ##[1:3] loadValid);
endmodule // fls_props

// ---- testbench.sv ----
// self-checking bench joining the core controller and the device
`timescale 1ns/1ps
module testbench;
    // clock, reset and stimulus
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0000;
    logic regWr = 1'b0, regRd = 1'b0, progMode = 1'b0, progSerial = 1'b0;
    logic fuseWrHigh = 1'b0, fuseWrLow = 1'b0, fuseWrExt = 1'b0, lockWr = 1'b0;
    logic chipErase = 1'b0, progWordHigh = 1'b0, er = 1'b0;
    logic [7:0] progMemData = 8'hC3, progWrData = 8'h00;
    logic [5:0] progWordAddr = 6'h00;
    // design outputs
    logic [15:0] regRdData, d;
    logic [7:0] progRdData, fuseHighActive, fuseLowActive, fuseExtActive;
    logic [7:0] fastOscTrim, slowOscTrim;
    logic eepromKeep, eepromErase;
    int n_mismatch = 0;
    int compares = 0;
    // table index and expected byte, reserved 0x06 last
    logic [5:0] tz [10] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h07, 6'h2C, 6'h2D, 6'h06};
    logic [7:0] tv [10] = '{8'h21, 8'h9A, 8'h43, 8'h12, 8'h65, 8'h34, 8'h7B, 8'hB1, 8'hF3, 8'hFF};

    // 100 MHz clock
    always #5 core_clk = ~core_clk;

    fls_link_if link ();
    // signature bytes are arbitrary values
    fls_device #(.SIG_BYTE0(8'h21), .SIG_BYTE1(8'h43), .SIG_BYTE2(8'h65), .FAST_TRIM(8'h9A),
        .SLOW_TRIM(8'h7B), .TEMP_TRIM_A(8'h12), .TEMP_TRIM_B(8'h34), .TS_GAIN(8'hB1),
        .TS_OFFSET(8'hF3)) fls_device_i (.core_clk, .rst, .link, .progMemData, .progMode,
        .progSerial, .fuseWrHigh, .fuseWrLow, .fuseWrExt, .lockWr, .chipErase, .progWrData,
        .progWordAddr, .progWordHigh, .progRdData, .fuseHighActive, .fuseLowActive,
        .fuseExtActive, .eepromKeep, .eepromErase, .fastOscTrim, .slowOscTrim);
    fls_core fls_core_i (.core_clk, .rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
        .link);
    fls_props fls_props_i (.core_clk(core_clk), .rst(rst), .armFuse(link.armFuse),
        .armSig(link.armSig), .loadValid(link.loadValid), .storeValid(link.storeValid),
        .zPtr(link.zPtr), .loadData(link.loadData), .loadDone(link.loadDone),
        .armActive(link.armActive));

    // verdict and end of run
    task automatic final_report();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // compare one byte
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one-cycle register write
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= v;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    // one-cycle register read, data taken in the following cycle
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 d = regRdData;
    endtask
    // armed read through the controller; done poll is bounded
    task automatic cfg(input logic [15:0] cmd, input logic [15:0] z, input logic [7:0] exp);
        int i;
        wr(fls_pkg::REG_ZPTR, z);
        wr(fls_pkg::REG_CMD, cmd);
        for (i = 0; i < 20; i++) begin
            rd(fls_pkg::REG_STATUS);
            if (d[0] === 1'b1) break;
        end
        if (i == 20) begin
            n_mismatch++;
            final_report();
        end
        rd(fls_pkg::REG_DATA);
        chk(d[7:0], exp);
    endtask
    // one programming pulse; erase request captured mid-pulse
    task automatic prog(input logic [4:0] k, input logic [7:0] v);
        @(posedge core_clk);
        fuseWrHigh <= k[4];
        fuseWrLow <= k[3];
        fuseWrExt <= k[2];
        lockWr <= k[1];
        chipErase <= k[0];
        progWrData <= v;
        #1 er = eepromErase;
        @(posedge core_clk);
        fuseWrHigh <= 1'b0;
        fuseWrLow <= 1'b0;
        fuseWrExt <= 1'b0;
        lockWr <= 1'b0;
        chipErase <= 1'b0;
        // step off the edge so callers see the stored result settled
        #1;
    endtask
    // external word read, byte answered one cycle later
    task automatic xrd(input logic [5:0] a, input logic h, input logic [7:0] exp);
        @(posedge core_clk);
        progWordAddr <= a;
        progWordHigh <= h;
        repeat (2) @(posedge core_clk);
        #1 chk(progRdData, exp);
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1 chk(fastOscTrim, 8'h9A);
        chk(slowOscTrim, 8'h7B);
        chk(fuseHighActive, 8'hDF);
        chk(fuseLowActive, 8'h6E);
        $display("test reset values done");
        cfg(16'h0001, fls_pkg::Z_FUSE_LOW, 8'h6E);
        cfg(16'h0001, fls_pkg::Z_FUSE_HIGH, 8'hDF);
        cfg(16'h0001, fls_pkg::Z_FUSE_EXT, 8'hFF);
        cfg(16'h0001, fls_pkg::Z_LOCK, 8'hFF);
        for (int k = 0; k < 10; k++) begin
            cfg(16'h0003, {10'h000, tz[k]}, tv[k]);
        end
        cfg(16'h0005, fls_pkg::Z_FUSE_LOW, 8'hC3);
        @(posedge core_clk);
        progMemData <= 8'h3C;
        cfg(16'h0007, fls_pkg::Z_FUSE_HIGH, 8'h3C);
        $display("test software reads done");
        @(posedge core_clk);
        progMode <= 1'b1;
        xrd(6'h01, 1'b0, 8'h43);
        xrd(6'h01, 1'b1, 8'h12);
        prog(5'h10, 8'hD7);
        chk({7'h00, eepromKeep}, 8'h01);
        chk(fuseHighActive, 8'hDF);
        prog(5'h08, 8'h52);
        chk(fuseLowActive, 8'h6E);
        prog(5'h01, 8'h00);
        chk({7'h00, er}, 8'h00);
        @(posedge core_clk);
        progSerial <= 1'b1;
        prog(5'h10, 8'hFF);
        @(posedge core_clk);
        progSerial <= 1'b0;
        chk({7'h00, eepromKeep}, 8'h00);
        prog(5'h01, 8'h00);
        chk({7'h00, er}, 8'h01);
        prog(5'h04, 8'hF7);
        prog(5'h02, 8'hFE);
        prog(5'h08, 8'hFF);
        @(posedge core_clk);
        progMode <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1 chk(fuseLowActive, 8'h5E);
        chk(fuseHighActive, 8'hDF);
        chk(fuseExtActive, 8'hF7);
        xrd(6'h00, 1'b0, 8'h21);
        cfg(16'h0001, fls_pkg::Z_LOCK, 8'hFE);
        cfg(16'h0003, 16'h0004, 8'h65);
        cfg(16'h0001, fls_pkg::Z_FUSE_EXT, 8'hF7);
        $display("test programming done");
        // reset-disable fuse shuts the serial route, parallel clears it
        @(posedge core_clk);
        progMode <= 1'b1;
        prog(5'h01, 8'h00);
        prog(5'h10, 8'h5F);
        @(posedge core_clk);
        progMode <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1 chk(fuseHighActive, 8'h5F);
        @(posedge core_clk);
        progMode <= 1'b1;
        progSerial <= 1'b1;
        prog(5'h09, 8'h00);
        chk({7'h00, er}, 8'h00);
        @(posedge core_clk);
        progSerial <= 1'b0;
        prog(5'h10, 8'hDF);
        @(posedge core_clk);
        progMode <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1 chk(fuseLowActive, 8'h5E);
        chk(fuseHighActive, 8'hDF);
        $display("test serial lockout done");
        final_report();
    end
endmodule // testbench
